// >>> inc/difl_pkg.sv
package difl_pkg;

    localparam int NTERM  = 8;
    localparam int CODE_W = 6;
    localparam int DW     = 16;
    localparam int AW     = 8;
    localparam int NFIX   = 16;

    // Terminal function codes
    localparam logic [CODE_W-1:0] FN_FIX0  = 6'h02;
    localparam logic [CODE_W-1:0] FN_FIX1  = 6'h03;
    localparam logic [CODE_W-1:0] FN_FIX2  = 6'h04;
    localparam logic [CODE_W-1:0] FN_FIX3  = 6'h05;
    localparam logic [CODE_W-1:0] FN_JOG   = 6'h06;
    localparam logic [CODE_W-1:0] FN_DCB   = 6'h07;
    localparam logic [CODE_W-1:0] FN_SET2  = 6'h08;
    localparam logic [CODE_W-1:0] FN_RAMP2 = 6'h09;
    localparam logic [CODE_W-1:0] FN_COAST = 6'h0b;
    localparam logic [CODE_W-1:0] FN_FAULT = 6'h0c;
    localparam logic [CODE_W-1:0] FN_GUARD = 6'h0d;
    localparam logic [CODE_W-1:0] FN_HEAVY = 6'h0e;
    localparam logic [CODE_W-1:0] FN_LOCK  = 6'h0f;
    localparam logic [CODE_W-1:0] FN_CLOOP = 6'h10;
    localparam logic [CODE_W-1:0] FN_THIRD_PARAM_SELECT  = 6'h11;
    localparam logic [CODE_W-1:0] FN_ACK   = 6'h12;
    localparam logic [CODE_W-1:0] FN_PRUN  = 6'h14;
    localparam logic [CODE_W-1:0] FN_PHALT = 6'h15;

    // Register byte addresses
    localparam logic [AW-1:0] A_CTRL  = 8'h00;
    localparam logic [AW-1:0] A_STAT  = 8'h04;
    localparam logic [AW-1:0] A_FNLO  = 8'h08;
    localparam logic [AW-1:0] A_FNHI  = 8'h0c;
    localparam logic [AW-1:0] A_INV   = 8'h10;
    localparam logic [AW-1:0] A_JOGF  = 8'h14;
    localparam logic [AW-1:0] A_JOGM  = 8'h18;
    localparam logic [AW-1:0] A_ACC1  = 8'h1c;
    localparam logic [AW-1:0] A_DEC1  = 8'h20;
    localparam logic [AW-1:0] A_ACC2  = 8'h24;
    localparam logic [AW-1:0] A_DEC2  = 8'h28;
    localparam logic [1:0]    FIX_SEL = 2'h1;

    localparam int CTRL_RUN = 0;
    localparam int CTRL_ACK = 1;

    localparam logic [7:0]    OUTSIDE_FAULT_CODE = 8'h0c;

    localparam logic [1:0] HALT_RAMP  = 2'h0;
    localparam logic [1:0] HALT_COAST = 2'h1;
    localparam logic [1:0] HALT_DCB   = 2'h2;

    localparam logic [DW-1:0] RST_TIME = 16'h0064;
    localparam logic [DW-1:0] RST_JOGF = 16'h0032;

    localparam logic [1:0] BANK_1 = 2'h0;
    localparam logic [1:0] BANK_2 = 2'h1;
    localparam logic [1:0] BANK_3 = 2'h2;

    typedef logic [NTERM-1:0][CODE_W-1:0] difl_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HALT
    } difl_state_t;

endpackage : difl_pkg

// >>> core/difl_core.sv
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module difl_core (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [difl_pkg::AW-1:0] avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic      [31:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic [difl_pkg::NTERM-1:0] term_i,
    input  wire logic                   mains_ok_i,
    input  wire logic                   zero_speed_i,
    input  wire logic [difl_pkg::DW-1:0] current_loop_reference_i,
    output logic                        drive_en_o,
    output logic      [difl_pkg::DW-1:0] freq_o,
    output logic      [difl_pkg::DW-1:0] accel_time_o,
    output logic      [difl_pkg::DW-1:0] decel_time_o,
    output logic                        dc_brake_en_o,
    output logic      [1:0]             param_bank_o,
    output logic                        heavy_start_o,
    output logic                        current_loop_select_o,
    output logic                        outside_fault_o,
    output logic      [7:0]             outside_fault_code_o,
    output logic                        running_o,
    output logic                        param_write_lock_o
);
    import difl_pkg::*;

    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NTERM-1:0]          t_m;
        logic [NTERM-1:0]          t_s;
        logic                      m_m;
        logic                      m_s;
        logic                      m_p;
        logic                      flt_p;
        logic                      ack_p;
        logic                      run_p;
        logic                      ctl_run;
        difl_cfg_t                 fn;
        logic [NTERM-1:0]          inv;
        logic [DW-1:0]             jogf;
        logic [1:0]                jogm;
        logic [DW-1:0]             acc1;
        logic [DW-1:0]             dec1;
        logic [DW-1:0]             acc2;
        logic [DW-1:0]             dec2;
        logic [NFIX-1:0][DW-1:0]   fix;
        difl_state_t               st;
        logic                      jog_run;
        logic                      latch;
        logic                      fault;
        logic                      guard_blk;
        logic                      bus_ack;
        logic [31:0]               rdata;
        logic                      drive;
        logic [DW-1:0]             freq;
        logic [DW-1:0]             acc;
        logic [DW-1:0]             dec;
        logic                      dcb;
        logic [1:0]                bank;
        logic                      heavy;
        logic                      cloop;
        logic                      lock;
    } difl_st_t;

    difl_st_t s_r;
    difl_st_t s_nxt;

    ////////////////////////////////////////////////////////////////
    // True when any terminal configured for code c is active
    function automatic logic fn_on(input logic [NTERM-1:0] lv,
                                   input difl_cfg_t cf,
                                   input logic [CODE_W-1:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (cf[i] == c && lv[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fn_on

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return m;
    endfunction : be_merge

    // Codes sit in the low six bits of each byte, upper two bits read 0
    function automatic logic [31:0] pack_codes(input logic [3:0][CODE_W-1:0] c);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            w[i*8 +: CODE_W] = c[i];
        end
        return w;
    endfunction : pack_codes

    ////////////////////////////////////////////////////////////////
    logic [NTERM-1:0] lvl;
    logic             f_coast;
    logic             f_fault;
    logic             f_ack;
    logic             f_guard;
    logic             f_jog;
    logic             f_prun;
    logic             f_phalt;
    logic [3:0]       fix_idx;
    logic [DW-1:0]    setpoint;
    logic             run_req;
    logic             kill;
    logic             sw_ack;
    logic             bus_req;
    logic             do_wr;
    logic [31:0]      old_w;
    logic [31:0]      mw;

    always_comb begin
        for (int i = 0; i < NTERM; i++) begin
            lvl[i] = s_r.t_s[i] ^ (s_r.inv[i] & (s_r.fn[i] != FN_ACK));
        end
    end

    assign f_coast  = fn_on(lvl, s_r.fn, FN_COAST);
    assign f_fault  = fn_on(lvl, s_r.fn, FN_FAULT);
    assign f_ack    = fn_on(lvl, s_r.fn, FN_ACK);
    assign f_guard  = fn_on(lvl, s_r.fn, FN_GUARD);
    assign f_jog    = fn_on(lvl, s_r.fn, FN_JOG);
    assign f_prun   = fn_on(lvl, s_r.fn, FN_PRUN);
    assign f_phalt  = fn_on(lvl, s_r.fn, FN_PHALT);
    assign fix_idx  = {fn_on(lvl, s_r.fn, FN_FIX3), fn_on(lvl, s_r.fn, FN_FIX2),
                       fn_on(lvl, s_r.fn, FN_FIX1), fn_on(lvl, s_r.fn, FN_FIX0)};

    // Stage zero is the normal setpoint; current loop replaces it outright
    assign setpoint = (fix_idx != 4'h0) ? s_r.fix[fix_idx] :
                      (s_r.cloop ? current_loop_reference_i : s_r.fix[0]);

    assign bus_req  = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~s_r.bus_ack;
    assign do_wr    = avs_write_i & s_r.bus_ack;
    assign sw_ack   = do_wr && avs_address_i == A_CTRL && avs_byteenable_i[0]
                      && avs_writedata_i[CTRL_ACK];

    assign run_req  = s_r.ctl_run | s_r.latch;
    // Any removal cause wins over a run request in the same cycle
    assign kill     = f_coast | s_r.fault | f_fault | f_ack | ~s_r.m_s;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        old_w = 32'h0000_0000;
        mw    = 32'h0000_0000;

        s_nxt.t_m   = term_i;
        s_nxt.t_s   = s_r.t_m;
        s_nxt.m_m   = mains_ok_i;
        s_nxt.m_s   = s_r.m_m;
        s_nxt.m_p   = s_r.m_s;
        s_nxt.flt_p = f_fault;
        s_nxt.ack_p = f_ack;
        s_nxt.run_p = f_prun;

        // Bus: one wait cycle, then answer
        s_nxt.bus_ack = bus_req & ~s_r.bus_ack;
        s_nxt.rdata   = 32'h0000_0000;
        if (avs_read_i) begin
            unique case (avs_address_i)
                A_CTRL: s_nxt.rdata = {30'h0, 1'b0, s_r.ctl_run};
                A_STAT: s_nxt.rdata = {8'h0, s_r.t_s, 8'h0, 2'h0, s_r.bank,
                                       s_r.lock, s_r.guard_blk, s_r.fault, s_r.drive};
                A_FNLO: s_nxt.rdata = pack_codes(s_r.fn[3:0]);
                A_FNHI: s_nxt.rdata = pack_codes(s_r.fn[7:4]);
                A_INV:  s_nxt.rdata = {24'h0, s_r.inv};
                A_JOGF: s_nxt.rdata = {16'h0, s_r.jogf};
                A_JOGM: s_nxt.rdata = {30'h0, s_r.jogm};
                A_ACC1: s_nxt.rdata = {16'h0, s_r.acc1};
                A_DEC1: s_nxt.rdata = {16'h0, s_r.dec1};
                A_ACC2: s_nxt.rdata = {16'h0, s_r.acc2};
                A_DEC2: s_nxt.rdata = {16'h0, s_r.dec2};
                default: begin
                    if (avs_address_i[7:6] == FIX_SEL) begin
                        s_nxt.rdata = {16'h0, s_r.fix[avs_address_i[5:2]]};
                    end
                end
            endcase
        end

        if (do_wr) begin
            unique case (avs_address_i)
                A_FNLO:  old_w = pack_codes(s_r.fn[3:0]);
                A_FNHI:  old_w = pack_codes(s_r.fn[7:4]);
                A_INV:   old_w = {24'h0, s_r.inv};
                default: old_w = 32'h0000_0000;
            endcase
            mw = be_merge(old_w, avs_writedata_i, avs_byteenable_i);
            if (avs_address_i == A_CTRL) begin
                if (avs_byteenable_i[0]) begin
                    s_nxt.ctl_run = avs_writedata_i[CTRL_RUN];
                end
            end else if (!s_r.lock) begin
                unique case (avs_address_i)
                    A_FNLO: for (int i = 0; i < 4; i++) s_nxt.fn[i] = mw[i*8 +: CODE_W];
                    A_FNHI: for (int i = 0; i < 4; i++) s_nxt.fn[i+4] = mw[i*8 +: CODE_W];
                    A_INV:  s_nxt.inv = mw[NTERM-1:0];
                    A_JOGF: if (avs_byteenable_i[1:0] == 2'h3) s_nxt.jogf = avs_writedata_i[DW-1:0];
                    A_JOGM: if (avs_byteenable_i[0]) s_nxt.jogm = avs_writedata_i[1:0];
                    A_ACC1: if (avs_byteenable_i[1:0] == 2'h3) s_nxt.acc1 = avs_writedata_i[DW-1:0];
                    A_DEC1: if (avs_byteenable_i[1:0] == 2'h3) s_nxt.dec1 = avs_writedata_i[DW-1:0];
                    A_ACC2: if (avs_byteenable_i[1:0] == 2'h3) s_nxt.acc2 = avs_writedata_i[DW-1:0];
                    A_DEC2: if (avs_byteenable_i[1:0] == 2'h3) s_nxt.dec2 = avs_writedata_i[DW-1:0];
                    default: begin
                        if (avs_address_i[7:6] == FIX_SEL && avs_byteenable_i[1:0] == 2'h3) begin
                            s_nxt.fix[avs_address_i[5:2]] = avs_writedata_i[DW-1:0];
                        end
                    end
                endcase
            end
        end

        // Fault latch: acknowledge clears, a new fault edge in the same cycle wins
        if ((f_ack & ~s_r.ack_p) | sw_ack) begin
            s_nxt.fault = 1'b0;
        end
        if (f_fault & ~s_r.flt_p) begin
            s_nxt.fault = 1'b1;
        end

        // Three-wire: halt level dominates a start pulse
        if (f_prun & ~s_r.run_p) begin
            s_nxt.latch = 1'b1;
        end
        if (f_phalt | kill) begin
            s_nxt.latch = 1'b0;
        end

        // Mains return with a start still present stays blocked until start drops
        if (s_r.m_s & ~s_r.m_p & f_guard & run_req) begin
            s_nxt.guard_blk = 1'b1;
        end else if (!run_req) begin
            s_nxt.guard_blk = 1'b0;
        end

        unique case (s_r.st)
            ST_IDLE: begin
                // A block raised in this very cycle must already hold the start back
                if (run_req & ~kill & ~s_nxt.guard_blk) begin
                    s_nxt.st      = ST_RUN;
                    s_nxt.jog_run = f_jog;
                end
            end
            ST_RUN: begin
                if (kill) begin
                    s_nxt.st = ST_IDLE;
                end else if (!run_req) begin
                    s_nxt.st = (s_r.jog_run && s_r.jogm == HALT_COAST) ? ST_IDLE : ST_HALT;
                end
            end
            ST_HALT: begin
                if (kill) begin
                    s_nxt.st = ST_IDLE;
                end else if (run_req & ~s_nxt.guard_blk) begin
                    s_nxt.st      = ST_RUN;
                    s_nxt.jog_run = f_jog;
                end else if (zero_speed_i) begin
                    s_nxt.st = ST_IDLE;
                end
            end
        endcase

        s_nxt.drive = (s_nxt.st != ST_IDLE);
        s_nxt.freq  = (s_nxt.st == ST_RUN) ? (s_nxt.jog_run ? s_r.jogf : setpoint) : '0;
        s_nxt.dcb   = ~kill & (fn_on(lvl, s_r.fn, FN_DCB) |
                      (s_nxt.st == ST_HALT && s_nxt.jog_run && s_r.jogm == HALT_DCB));
        s_nxt.acc   = fn_on(lvl, s_r.fn, FN_RAMP2) ? s_r.acc2 : s_r.acc1;
        s_nxt.dec   = fn_on(lvl, s_r.fn, FN_RAMP2) ? s_r.dec2 : s_r.dec1;
        s_nxt.bank  = fn_on(lvl, s_r.fn, FN_THIRD_PARAM_SELECT) ? BANK_3 :
                      (fn_on(lvl, s_r.fn, FN_SET2) ? BANK_2 : BANK_1);
        s_nxt.heavy = fn_on(lvl, s_r.fn, FN_HEAVY);
        s_nxt.cloop = fn_on(lvl, s_r.fn, FN_CLOOP);
        s_nxt.lock  = fn_on(lvl, s_r.fn, FN_LOCK);
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.jogf <= RST_JOGF;
            s_r.acc1 <= RST_TIME;
            s_r.dec1 <= RST_TIME;
            s_r.acc2 <= RST_TIME;
            s_r.dec2 <= RST_TIME;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata_o        = s_r.rdata;
    assign drive_en_o            = s_r.drive;
    assign running_o             = (s_r.st == ST_RUN);
    assign freq_o                = s_r.freq;
    assign accel_time_o          = s_r.acc;
    assign decel_time_o          = s_r.dec;
    assign dc_brake_en_o         = s_r.dcb;
    assign param_bank_o          = s_r.bank;
    assign heavy_start_o         = s_r.heavy;
    assign current_loop_select_o = s_r.cloop;
    assign outside_fault_o       = s_r.fault;
    assign outside_fault_code_o  = s_r.fault ? OUTSIDE_FAULT_CODE : 8'h00;
    assign param_write_lock_o    = s_r.lock;

endmodule : difl_core

`default_nettype wire

// >>> verification/difl_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module difl_checker
    import difl_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic [AW-1:0]   avs_address_i,
    input wire logic            avs_read_i,
    input wire logic            avs_write_i,
    input wire logic [31:0]     avs_writedata_i,
    input wire logic [3:0]      avs_byteenable_i,
    input wire logic [31:0]     avs_readdata_o,
    input wire logic            avs_waitrequest_o,
    input wire logic            mains_ok_i,
    input wire logic            zero_speed_i,
    input wire logic            drive_en_o,
    input wire logic [DW-1:0]   freq_o,
    input wire logic [1:0]      param_bank_o,
    input wire logic            outside_fault_o,
    input wire logic [7:0]      outside_fault_code_o,
    input wire logic            running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    sequence s_req_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_one_wait: assert property (s_req_wait |=> s_answer)
        else $error("bus answer not after one wait state");
    a_first_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
        else $error("read answered without wait state");
    a_unmapped_zero: assert property (s_answer and avs_read_i && avs_address_i == 8'h30 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_fault_code: assert property (outside_fault_o |-> outside_fault_code_o == OUTSIDE_FAULT_CODE && !running_o)
        else $error("fault code does not match latch");
    a_fault_off: assert property (outside_fault_o [*2] |-> !drive_en_o)
        else $error("drive on while fault latched");
    a_ctrl_ack: assert property (s_answer and avs_write_i && avs_address_i == A_CTRL && avs_writedata_i[CTRL_ACK]
                                 && avs_byteenable_i[0] |=> !outside_fault_o)
        else $error("register acknowledge left fault latched");
    a_run_drive: assert property (running_o |-> drive_en_o && freq_o != 16'h0000 || drive_en_o)
        else $error("running without drive");
    a_idle_freq: assert property (!running_o |-> freq_o == 16'h0000)
        else $error("frequency outside run");
    a_mains_off: assert property (!mains_ok_i [*4] |-> !drive_en_o)
        else $error("drive on without mains");
    a_halt_end: assert property (drive_en_o && !running_o && zero_speed_i |=> !(drive_en_o && !running_o))
        else $error("halt not ended at standstill");
    a_bank_legal: assert property (param_bank_o != 2'h3)
        else $error("illegal parameter bank");
endmodule : difl_checker
bind difl_core difl_checker u_chk (.*);
`default_nettype wire

// >>> verification/difl_switches.sv
`timescale 1ns/1ps
`default_nettype none
module difl_switches (
    input  wire logic       clk_i,
    output logic [7:0]      term_o,
    output logic            mains_ok_o
);
    initial begin
        term_o     = 8'h00;
        mains_ok_o = 1'b1;
    end
    // Momentary contact: long enough for the synchroniser, then open again
    task automatic pulse(input int t);
        @(posedge clk_i);
        term_o[t] <= 1'b1;
        repeat (2) @(posedge clk_i);
        term_o[t] <= 1'b0;
    endtask : pulse
    task automatic hold(input int t, input logic v);
        @(posedge clk_i);
        term_o[t] <= v;
    endtask : hold
    task automatic set_mains(input logic v);
        @(posedge clk_i);
        mains_ok_o <= v;
    endtask : set_mains
endmodule : difl_switches
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import difl_pkg::*;
    logic           clk_i = 1'b0, rst_i = 1'b1, zero_speed_i = 1'b0;
    logic [AW-1:0]  avs_address_i = '0;
    logic           avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0]     avs_byteenable_i = 4'hf, be_m = 4'hf;
    logic [31:0]    avs_writedata_i = '0, avs_readdata_o, rd, rng = 32'd58;
    logic           avs_waitrequest_o, mains_ok_i, drive_en_o, dc_brake_en_o, heavy_start_o;
    logic           current_loop_select_o, outside_fault_o, running_o, param_write_lock_o;
    logic [NTERM-1:0] term_i;
    logic [DW-1:0]  current_loop_reference_i = '0, freq_o, accel_time_o, decel_time_o, sp, jf;
    logic [1:0]     param_bank_o;
    logic [7:0]     outside_fault_code_o;
    int             failures = 0, cmp_count = 0, lock_m = 0;
    int             regs[int];
    int             kill[2] = '{2, 4};

    always #4 clk_i = ~clk_i;
    difl_core u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .term_i(term_i),
        .mains_ok_i(mains_ok_i), .zero_speed_i(zero_speed_i), .current_loop_reference_i(current_loop_reference_i),
        .drive_en_o(drive_en_o), .freq_o(freq_o), .accel_time_o(accel_time_o), .decel_time_o(decel_time_o),
        .dc_brake_en_o(dc_brake_en_o), .param_bank_o(param_bank_o), .heavy_start_o(heavy_start_o),
        .current_loop_select_o(current_loop_select_o), .outside_fault_o(outside_fault_o),
        .outside_fault_code_o(outside_fault_code_o), .running_o(running_o), .param_write_lock_o(param_write_lock_o)
    );
    difl_switches u_sw (.clk_i(clk_i), .term_o(term_i), .mains_ok_o(mains_ok_i));
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd16();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0] | 16'h0001;
    endfunction : rnd16
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be_m;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rd = avs_readdata_o;
        if (n >= 50) chk(32'h0, 32'h1, "bus timeout");
        if (wr && be_m == 4'hf && (lock_m == 0 || a == A_CTRL)) regs[a] = d;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        chk(rd, regs.exists(a) ? regs[a] : 0, "readback");
    endtask : rdchk
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic outs(input logic drv, input logic run, input logic [15:0] f);
        chk({14'h0, drive_en_o, running_o, freq_o}, {14'h0, drv, run, f}, "drive state");
    endtask : outs
    task automatic start_stop(input bit jog);
        u_sw.pulse(0);
        settle();
        outs(1'b1, 1'b1, jog ? jf : sp);
        u_sw.pulse(1);
        settle();
        outs(1'b1, 1'b0, 16'h0);
        @(posedge clk_i);
        zero_speed_i <= 1'b1;
        settle();
        outs(1'b0, 1'b0, 16'h0);
        @(posedge clk_i);
        zero_speed_i <= 1'b0;
    endtask : start_stop
    ////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    initial begin
        regs[A_JOGF] = 32'h32;
        regs[A_ACC1] = 32'h64;
        regs[A_DEC1] = 32'h64;
        regs[A_ACC2] = 32'h64;
        regs[A_DEC2] = 32'h64;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk({accel_time_o, decel_time_o}, {RST_TIME, RST_TIME}, "reset times");
        outs(1'b0, 1'b0, 16'h0);
        foreach (regs[a]) rdchk(8'(a));
        rdchk(8'h30);
        $display("test reset done");
        bus(1'b1, A_FNLO, {2'b0, FN_FAULT, 2'b0, FN_COAST, 2'b0, FN_PHALT, 2'b0, FN_PRUN});
        bus(1'b1, A_FNHI, {2'b0, FN_JOG, 2'b0, FN_RAMP2, 2'b0, FN_LOCK, 2'b0, FN_ACK});
        sp = rnd16();
        jf = rnd16();
        current_loop_reference_i <= rnd16();
        bus(1'b1, 8'h40, {16'h0, sp});
        bus(1'b1, A_JOGF, {16'h0, jf});
        bus(1'b1, A_ACC2, {16'h0, rnd16()});
        foreach (regs[a]) rdchk(8'(a));
        $display("test config done");
        start_stop(1'b0);
        u_sw.hold(6, 1'b1);
        settle();
        chk(accel_time_o, regs[A_ACC2], "second ramp");
        u_sw.hold(7, 1'b1);
        start_stop(1'b1);
        u_sw.hold(7, 1'b0);
        u_sw.hold(6, 1'b0);
        settle();
        chk(accel_time_o, regs[A_ACC1], "first ramp");
        $display("test run done");
        foreach (kill[i]) begin
            u_sw.pulse(0);
            settle();
            outs(1'b1, 1'b1, sp);
            u_sw.hold(kill[i], 1'b1);
            settle();
            outs(1'b0, 1'b0, 16'h0);
            u_sw.pulse(0);
            settle();
            outs(1'b0, 1'b0, 16'h0);
            u_sw.hold(kill[i], 1'b0);
            u_sw.pulse(1);
            settle();
        end
        $display("test kill done");
        u_sw.pulse(0);
        u_sw.pulse(3);
        settle();
        chk({outside_fault_o, outside_fault_code_o, drive_en_o}, {1'b1, OUTSIDE_FAULT_CODE, 1'b0}, "fault");
        u_sw.pulse(1);
        repeat (20) @(posedge clk_i);
        chk(outside_fault_o, 1'b1, "fault held");
        u_sw.pulse(4);
        settle();
        chk(outside_fault_o, 1'b0, "fault acknowledge");
        u_sw.pulse(3);
        settle();
        bus(1'b1, A_CTRL, 32'h2);
        settle();
        chk(outside_fault_o, 1'b0, "register acknowledge");
        $display("test fault done");
        u_sw.hold(5, 1'b1);
        settle();
        lock_m = 1;
        chk(param_write_lock_o, 1'b1, "lock level");
        bus(1'b1, A_JOGF, {16'h0, rnd16()});
        rdchk(A_JOGF);
        u_sw.hold(5, 1'b0);
        settle();
        lock_m = 0;
        bus(1'b1, A_JOGF, {16'h0, rnd16()});
        rdchk(A_JOGF);
        $display("test lock done");
        u_sw.pulse(0);
        settle();
        outs(1'b1, 1'b1, sp);
        u_sw.set_mains(1'b0);
        settle();
        outs(1'b0, 1'b0, 16'h0);
        u_sw.set_mains(1'b1);
        u_sw.pulse(1);
        settle();
        $display("test mains done");
        bus(1'b1, A_FNLO, {2'b0, FN_DCB, 2'b0, FN_CLOOP, 2'b0, FN_HEAVY, 2'b0, FN_SET2});
        bus(1'b1, A_FNHI, {2'b0, FN_FIX1, 2'b0, FN_FIX0, 2'b0, FN_THIRD_PARAM_SELECT, 2'b0, FN_GUARD});
        for (int t = 0; t < 5; t++) u_sw.hold(t, 1'b1);
        settle();
        chk({dc_brake_en_o, current_loop_select_o, heavy_start_o, param_bank_o}, {3'h7, BANK_2}, "levels");
        bus(1'b1, A_CTRL, 32'h1);
        settle();
        outs(1'b1, 1'b1, current_loop_reference_i);
        sp = rnd16();
        bus(1'b1, 8'h44, {16'h0, sp});
        be_m = 4'h1;
        bus(1'b1, 8'h44, 32'h0);
        be_m = 4'hf;
        rdchk(8'h44);
        u_sw.hold(6, 1'b1);
        settle();
        outs(1'b1, 1'b1, sp);
        u_sw.hold(5, 1'b1);
        settle();
        chk(param_bank_o, BANK_3, "third bank");
        u_sw.set_mains(1'b0);
        settle();
        u_sw.set_mains(1'b1);
        repeat (2) settle();
        outs(1'b0, 1'b0, 16'h0);
        bus(1'b1, A_CTRL, 32'h0);
        bus(1'b1, A_CTRL, 32'h1);
        settle();
        outs(1'b1, 1'b1, sp);
        $display("test functions done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
